// File: hw/timer_mode_pkg.sv
package timer_mode_pkg;

  localparam int unsigned CNT_W = 32;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] CMD_OFS         = 8'h04;
  localparam logic [7:0] STATUS_OFS      = 8'h08;
  localparam logic [7:0] COUNT_OFS       = 8'h0C;
  localparam logic [7:0] COMPARE_OFS     = 8'h10;
  localparam logic [7:0] COMPARE_SH_OFS  = 8'h14;
  localparam logic [7:0] PERIOD_OFS      = 8'h18;
  localparam logic [7:0] PERIOD_SH_OFS   = 8'h1C;

  // Control register fields
  localparam int unsigned PRESC_LSB      = 8;
  localparam int unsigned PRESC_MSB      = 10;
  localparam int unsigned STYLE_LSB      = 16;
  localparam int unsigned STYLE_MSB      = 17;
  localparam int unsigned ONE_SHOT_BIT   = 18;
  localparam int unsigned SWAP_BIT       = 19;
  localparam int unsigned MODE_LSB       = 24;
  localparam int unsigned MODE_MSB       = 26;
  localparam int unsigned ENABLE_BIT     = 31;

  // Command register bits
  localparam int unsigned CMD_RELOAD_BIT = 0;
  localparam int unsigned CMD_START_BIT  = 1;
  localparam int unsigned CMD_STOP_BIT   = 2;

  // Status register bits
  localparam int unsigned STAT_RUN_BIT   = 0;
  localparam int unsigned STAT_DOWN_BIT  = 1;

  // Reset values
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [31:0] COMPARE_RST    = 32'h0000_0000;
  localparam logic [31:0] PERIOD_RST     = 32'hFFFF_FFFF;

  localparam logic [2:0] MODE_TIMER      = 3'b000;

  typedef enum logic [1:0] {
    STYLE_UP          = 2'b00,
    STYLE_DOWN        = 2'b01,
    style_updown_one  = 2'b10,
    style_updown_two  = 2'b11
  } style_t;

endpackage

// File: hw/timer_mode_counter.sv
`timescale 1ns/1ps
`default_nettype none

module timer_mode_counter
  import timer_mode_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reload_in,
  input  wire logic        start_in,
  input  wire logic        stop_in,
  input  wire logic        count_in,
  output logic             compare_hit_event,
  output logic             overflow_event,
  output logic             underflow_event,
  output logic             terminal_count_event,
  output logic             running
);

  logic [31:0]      ctrl_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] compare_value;
  logic [CNT_W-1:0] compare_value_shadow;
  logic [CNT_W-1:0] period_reg;
  logic [CNT_W-1:0] period_limit_shadow;
  logic             running_reg;
  logic             down_reg;
  logic             reload_pend_reg;
  logic [7:0]       presc_reg;
  logic             hit_d_reg;
  logic             ovf_d_reg;
  logic             unf_d_reg;
  logic             tc_d_reg;

  logic             wr_en;
  logic             rd_setup;
  logic             cmd_wr;
  logic             count_wr;
  logic             reload_req;
  logic             start_req;
  logic             stop_req;
  logic [2:0]       presc_sel;
  logic [7:0]       presc_mask;
  logic             tick;
  logic             active;
  logic             timer_on;
  logic             fire_reload;
  logic             step;
  style_t           style;
  logic             one_shot;
  logic             hit_now;
  logic             ovf_now;
  logic             unf_now;
  logic             tc_now;
  logic             hw_stop;
  logic             mapped;

  assign style     = style_t'(ctrl_reg[STYLE_MSB:STYLE_LSB]);
  assign one_shot  = ctrl_reg[ONE_SHOT_BIT];
  assign presc_sel = ctrl_reg[PRESC_MSB:PRESC_LSB];
  assign timer_on  = ctrl_reg[ENABLE_BIT] &&
                     (ctrl_reg[MODE_MSB:MODE_LSB] == MODE_TIMER);

  // APB decode; one wait-free access phase
  assign wr_en    = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;
  assign mapped   = (paddr[1:0] == 2'b00) && (paddr <= PERIOD_SH_OFS);
  assign cmd_wr   = wr_en && (paddr == CMD_OFS);
  assign count_wr = wr_en && (paddr == COUNT_OFS) && !running_reg;

  assign reload_req = reload_in || (cmd_wr && pwdata[CMD_RELOAD_BIT]);
  assign start_req  = start_in  || (cmd_wr && pwdata[CMD_START_BIT]);
  assign stop_req   = stop_in   || (cmd_wr && pwdata[CMD_STOP_BIT]);

  // Prescaler divides by 2^sel
  assign presc_mask = 8'((9'h001 << presc_sel) - 9'h001);
  assign tick       = (presc_reg & presc_mask) == presc_mask;
  assign active     = timer_on && tick && count_in;

  // Reload lands on the first active edge
  assign fire_reload = active && (reload_pend_reg || reload_req);
  assign step        = active && !fire_reload && running_reg;

  // Events from the value being left
  assign hit_now = step && (count_reg == compare_value);
  assign ovf_now = step && !down_reg && (count_reg == period_reg);
  assign unf_now = step && down_reg && (count_reg == '0);

  always_comb begin
    case (style)
      STYLE_UP:         tc_now = ovf_now;
      STYLE_DOWN:       tc_now = unf_now;
      style_updown_one: tc_now = unf_now;
      style_updown_two: tc_now = ovf_now || unf_now;
      default:          tc_now = 1'b0;
    endcase
  end

  assign hw_stop = one_shot &&
                   ((style == STYLE_UP) ? ovf_now : unf_now);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      presc_reg <= 8'h00;
    end else if (!timer_on || fire_reload) begin
      presc_reg <= 8'h00;
    end else begin
      presc_reg <= presc_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reload_pend_reg <= 1'b0;
    end else if (fire_reload) begin
      reload_pend_reg <= 1'b0;
    end else if (reload_req) begin
      reload_pend_reg <= 1'b1;
    end
  end

  // Count, direction and run state
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      count_reg   <= '0;
      down_reg    <= 1'b0;
      running_reg <= 1'b0;
    end else begin
      if (count_wr) begin
        count_reg <= pwdata;
      end
      if (fire_reload) begin
        running_reg <= 1'b1;
        case (style)
          STYLE_UP: begin
            count_reg <= '0;
            down_reg  <= 1'b0;
          end
          STYLE_DOWN: begin
            count_reg <= period_reg;
            down_reg  <= 1'b1;
          end
          default: begin
            count_reg <= CNT_W'(1);
            down_reg  <= 1'b0;
          end
        endcase
      end else if (stop_req || hw_stop) begin
        running_reg <= 1'b0;
      end else if (start_req && !running_reg) begin
        running_reg <= 1'b1;
        if (style == STYLE_UP) begin
          down_reg <= 1'b0;
        end else if (style == STYLE_DOWN) begin
          down_reg <= 1'b1;
        end
      end
      if (step) begin
        case (style)
          STYLE_UP:
            count_reg <= ovf_now ? '0 : count_reg + 1'b1;
          STYLE_DOWN:
            count_reg <= unf_now ? period_reg : count_reg - 1'b1;
          default: begin
            if (ovf_now) begin
              down_reg  <= 1'b1;
              count_reg <= count_reg - 1'b1;
            end else if (unf_now) begin
              down_reg  <= 1'b0;
              count_reg <= count_reg + 1'b1;
            end else if (down_reg) begin
              count_reg <= count_reg - 1'b1;
            end else begin
              count_reg <= count_reg + 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      compare_value        <= COMPARE_RST;
      compare_value_shadow <= COMPARE_RST;
    end else if (hit_now && ctrl_reg[SWAP_BIT]) begin
      compare_value        <= compare_value_shadow;
      compare_value_shadow <= compare_value;
    end else if (wr_en && paddr == COMPARE_OFS) begin
      compare_value <= pwdata;
    end else if (wr_en && paddr == COMPARE_SH_OFS) begin
      compare_value_shadow <= pwdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl_reg            <= CTRL_RST;
      period_reg          <= PERIOD_RST;
      period_limit_shadow <= PERIOD_RST;
    end else if (wr_en) begin
      if (paddr == CTRL_OFS) begin
        ctrl_reg <= pwdata;
      end
      if (paddr == PERIOD_OFS) begin
        period_reg <= pwdata;
      end
      if (paddr == PERIOD_SH_OFS) begin
        period_limit_shadow <= pwdata;
      end
    end
  end

  // Two-cycle output stretch
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      hit_d_reg            <= 1'b0;
      ovf_d_reg            <= 1'b0;
      unf_d_reg            <= 1'b0;
      tc_d_reg             <= 1'b0;
      compare_hit_event    <= 1'b0;
      overflow_event       <= 1'b0;
      underflow_event      <= 1'b0;
      terminal_count_event <= 1'b0;
      running              <= 1'b0;
    end else begin
      hit_d_reg            <= hit_now;
      ovf_d_reg            <= ovf_now;
      unf_d_reg            <= unf_now;
      tc_d_reg             <= tc_now;
      compare_hit_event    <= hit_now || hit_d_reg;
      overflow_event       <= ovf_now || ovf_d_reg;
      underflow_event      <= unf_now || unf_d_reg;
      terminal_count_event <= tc_now || tc_d_reg;
      running              <= running_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_setup;
      pslverr <= rd_setup && !mapped;
      if (rd_setup) begin
        case (paddr)
          CTRL_OFS:       prdata <= ctrl_reg;
          STATUS_OFS:     prdata <= {30'h0, down_reg, running_reg};
          COUNT_OFS:      prdata <= count_reg;
          COMPARE_OFS:    prdata <= compare_value;
          COMPARE_SH_OFS: prdata <= compare_value_shadow;
          PERIOD_OFS:     prdata <= period_reg;
          PERIOD_SH_OFS:  prdata <= period_limit_shadow;
          default:        prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  stop_clears_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    stop_req && !fire_reload |=> !running_reg)
    else $error("stop did not halt counter");

  idle_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !running_reg && !fire_reload && !count_wr |=> $stable(count_reg))
    else $error("idle count changed");

  step_up_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    step && !down_reg && !ovf_now && !count_wr
    |=> count_reg == $past(count_reg) + 1'b1)
    else $error("up step not by one");

  reload_up_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    fire_reload && style == STYLE_UP
    |=> count_reg == '0 && !down_reg && running_reg)
    else $error("up reload wrong");

  reload_down_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    fire_reload && style == STYLE_DOWN
    |=> count_reg == $past(period_reg) && down_reg && running_reg)
    else $error("down reload wrong");

  reload_updown_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    fire_reload && style[1] |=> count_reg == CNT_W'(1) && !down_reg)
    else $error("updown reload wrong");

  start_ignored_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    running_reg && start_req && !stop_req && !fire_reload && !step
    |=> $stable(down_reg) && $stable(count_reg))
    else $error("start acted while running");

  one_shot_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    hw_stop && !fire_reload |=> !running_reg ##1 !running)
    else $error("one-shot did not stop");

  swap_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    hit_now && ctrl_reg[SWAP_BIT]
    |=> compare_value == $past(compare_value_shadow))
    else $error("compare swap missing");

  pulse_two_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    hit_now |=> compare_hit_event [*2])
    else $error("compare pulse not two cycles");

  pulse_end_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    hit_now ##1 !hit_now [*2] |=> !compare_hit_event)
    else $error("compare pulse longer than two cycles");

  tc_map_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    style == style_updown_one && ovf_now |-> !tc_now)
    else $error("terminal count mapping wrong");

  tc_two_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    style == style_updown_two && ovf_now |=> terminal_count_event)
    else $error("style two overflow gave no terminal count");

endmodule

`default_nettype wire

// File: dv/trigger_source_model.sv
`timescale 1ns/1ps
`default_nettype none

module trigger_source_model (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic [2:0] fire,
  input  wire logic       count_on,
  output logic            reload_in,
  output logic            start_in,
  output logic            stop_in,
  output logic            count_in
);
  // One-cycle trigger pulses; count level follows the request
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      {stop_in, start_in, reload_in} <= 3'h0;
      count_in <= 1'b0;
    end else begin
      {stop_in, start_in, reload_in} <= fire;
      count_in <= count_on;
    end
  end
endmodule

`default_nettype wire

// File: dv/test_timer_mode_counter.sv
`timescale 1ns/1ps
`default_nettype none

module test_timer_mode_counter import timer_mode_pkg::*;;
  typedef struct {
    logic [1:0]  st;
    logic [2:0]  ps;
    logic        sw;
    logic [31:0] cc;
    int          ov, un, tc, hit;
  } row_t;
  row_t rows[7] = '{
    '{STYLE_UP, 3'h0, 1'b0, 32'h2, 1, 0, 1, 1},
    '{STYLE_DOWN, 3'h0, 1'b1, 32'h2, 0, 1, 1, 1},
    '{style_updown_one, 3'h0, 1'b1, 32'h2, 1, 1, 1, 1},
    '{style_updown_two, 3'h0, 1'b0, 32'h2, 1, 1, 2, 2},
    '{style_updown_one, 3'h0, 1'b0, 32'h0, 1, 1, 1, 1},
    '{style_updown_two, 3'h0, 1'b0, 32'h4, 1, 1, 2, 1},
    '{STYLE_UP, 3'h1, 1'b0, 32'h2, 1, 0, 1, 1}};
  logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, ctl, c1;
  logic        er, reload_in, start_in, stop_in, count_in, count_on;
  logic        compare_hit_event, overflow_event, underflow_event;
  logic        terminal_count_event, running, prun;
  logic [2:0]  fire;
  logic [3:0]  prev;
  int          fail_count, samples_checked, cyc, t_up, t_dn, steps, dv;
  int          n_ov, n_un, n_tc, n_hit;
  logic [7:0]  ofs[4] = '{CTRL_OFS, PERIOD_OFS, COMPARE_OFS, STATUS_OFS};
  logic [31:0] rst_v[4] = '{CTRL_RST, PERIOD_RST, COMPARE_RST, 32'h0};

  timer_mode_counter u_timer_mode_counter (.ref_clk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .reload_in, .start_in, .stop_in, .count_in, .compare_hit_event,
    .overflow_event, .underflow_event, .terminal_count_event, .running);
  trigger_source_model u_trigger_source_model (.ref_clk, .rstn, .fire,
    .count_on, .reload_in, .start_in, .stop_in, .count_in);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Event rising edges and running transitions
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    prun <= running;
    prev <= {compare_hit_event, overflow_event, underflow_event,
             terminal_count_event};
    if (compare_hit_event && !prev[3]) n_hit <= n_hit + 1;
    if (overflow_event && !prev[2]) n_ov <= n_ov + 1;
    if (underflow_event && !prev[1]) n_un <= n_un + 1;
    if (terminal_count_event && !prev[0]) n_tc <= n_tc + 1;
    if (running && !prun) t_up <= cyc;
    if (!running && prun) t_dn <= cyc;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task pulse(input logic [2:0] f);
    @(posedge ref_clk);
    fire <= f;
    @(posedge ref_clk);
    fire <= 3'h0;
  endtask

  task wait_run(input logic v);
    int n;
    n = 0;
    while (running !== v && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    if (running !== v) fail_count++;
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    test_done;
  end

  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, fire} = '0;
    {fail_count, samples_checked, cyc, t_up, t_dn} = '0;
    count_on = 1'b1;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      // Setup only while stopped
      apb(1'b1, PERIOD_OFS, 32'h4);
      apb(1'b1, COMPARE_OFS, rows[i].cc);
      apb(1'b1, COMPARE_SH_OFS, 32'h7);
      ctl = '0;
      ctl[ENABLE_BIT] = 1'b1;
      ctl[ONE_SHOT_BIT] = 1'b1;
      ctl[SWAP_BIT] = rows[i].sw;
      ctl[STYLE_MSB:STYLE_LSB] = rows[i].st;
      ctl[PRESC_MSB:PRESC_LSB] = rows[i].ps;
      apb(1'b1, CTRL_OFS, ctl);
      {n_ov, n_un, n_tc, n_hit} = '0;
      apb(1'b1, CMD_OFS, 32'h1);
      wait_run(1'b1);
      wait_run(1'b0);
      repeat (4) @(posedge ref_clk);
      check(n_ov, rows[i].ov);
      check(n_un, rows[i].un);
      check(n_tc, rows[i].tc);
      check(n_hit, rows[i].hit);
      steps = (rows[i].st[1]) ? 8 : 5;
      dv = 1 << rows[i].ps;
      check(t_dn - t_up > steps * dv - dv && t_dn - t_up < steps * dv + dv,
            1);
      apb(1'b0, COMPARE_OFS, 32'h0);
      check(rd, (rows[i].sw && rows[i].hit[0]) ? 32'h7 : rows[i].cc);
    end
    @(posedge ref_clk);
    count_on <= 1'b0;
    ctl = '0;
    ctl[ENABLE_BIT] = 1'b1;
    apb(1'b1, PERIOD_OFS, 32'hFF);
    apb(1'b1, CTRL_OFS, ctl);
    apb(1'b1, CMD_OFS, 32'h1);
    repeat (6) @(posedge ref_clk);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rd[STAT_RUN_BIT], 1'b0);
    count_on <= 1'b1;
    repeat (20) @(posedge ref_clk);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rd[STAT_RUN_BIT], 1'b1);
    pulse(3'h4);
    repeat (3) @(posedge ref_clk);
    apb(1'b0, COUNT_OFS, 32'h0);
    c1 = rd;
    repeat (6) @(posedge ref_clk);
    apb(1'b0, COUNT_OFS, 32'h0);
    check(rd, c1);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rd[1:0], 2'h0);
    ctl[STYLE_MSB:STYLE_LSB] = STYLE_DOWN;
    apb(1'b1, CTRL_OFS, ctl);
    pulse(3'h2);
    repeat (3) @(posedge ref_clk);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rd[1:0], 2'h3);
    apb(1'b0, COUNT_OFS, 32'h0);
    check(rd < c1, 1'b1);
    // Non-timer mode freezes the count; start while running is ignored
    ctl[MODE_MSB:MODE_LSB] = 3'b010;
    ctl[STYLE_MSB:STYLE_LSB] = STYLE_UP;
    apb(1'b1, CTRL_OFS, ctl);
    apb(1'b0, COUNT_OFS, 32'h0);
    c1 = rd;
    pulse(3'h2);
    repeat (3) @(posedge ref_clk);
    apb(1'b0, COUNT_OFS, 32'h0);
    check(rd, c1);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rd[1:0], 2'h3);
    apb(1'b1, CMD_OFS, 32'h4);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rd[STAT_RUN_BIT], 1'b0);
    ctl[MODE_MSB:MODE_LSB] = MODE_TIMER;
    apb(1'b1, CTRL_OFS, ctl);
    pulse(3'h1);
    repeat (2) @(posedge ref_clk);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rd[1:0], 2'h1);
    apb(1'b0, 8'h20, 32'h0);
    check(er, 1'b1);
    check(rd, 32'h0);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0);
      check(rd, rst_v[i]);
    end
    check(running, 1'b0);
    test_done;
  end
endmodule

`default_nettype wire
